// *** vhc_map.vh ***
`ifndef VHC_MAP_VH
`define VHC_MAP_VH

// command codes
`define VHC_OP_TRIG 8'h09
`define VHC_OP_UNLOCK 8'h0A
`define VHC_OP_WRCFG 8'h0B
`define VHC_SUB_WRCFG 8'h07
`define VHC_OP_RDSTAT 8'h17
`define VHC_SUB_ZERO 8'h00

// command lengths in bytes, code byte counted as byte 1
`define VHC_LEN_BARE 5'h01
`define VHC_LEN_RDSTAT 5'h03
`define VHC_LEN_WRCFG 5'h1D
`define VHC_LEN_CAP 5'h1F
`define VHC_POS_CODE 5'h01
`define VHC_POS_SUB 5'h02
`define VHC_POS_ARG 5'h03
`define VHC_MASK_FIRST 5'h03

// configuration block mask
`define VHC_NBLK 213
`define VHC_MASK_W 216

// statistics block layout, bytes
`define VHC_SIG_BYTES 8'h02
`define VHC_TOOL_BYTES 8'h12
`define VHC_FEAT_TOOL_BYTES 8'h36
`define VHC_STAT_MAX 8'h80

// hex character encoding
`define VHC_ASCII_ZERO 8'h30
`define VHC_ASCII_ALPHA 8'h37
`define VHC_NIB_TEN 4'hA

`endif

// *** vhc_stat_tx.v ***
`timescale 1ns/1ns
`include "vhc_map.vh"

module vhc_stat_tx #(
    parameter AW = 7
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rstn_i,
    // control
    input wire start_i,
    input wire [7:0] len_i,
    output reg busy_o,
    // statistics memory, combinational read of mem_addr_o, byte taken the cycle after the address moves
    output reg [AW-1:0] mem_addr_o,
    input wire [7:0] mem_data_i,
    // character stream
    output reg [7:0] char_o,
    output reg valid_o,
    input wire ready_i
);
    localparam S_IDLE = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_HI = 2'h2;
    localparam S_LO = 2'h3;

    reg [1:0] state_q;
    reg [7:0] byte_q;
    reg [7:0] left_q;

    function [7:0] hex_char;
        input [3:0] nib;
        begin
            if (nib < `VHC_NIB_TEN)
                hex_char = `VHC_ASCII_ZERO + {4'h0, nib};
            else
                hex_char = `VHC_ASCII_ALPHA + {4'h0, nib};
        end
    endfunction

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= S_IDLE;
            byte_q <= 8'h00;
            left_q <= 8'h00;
            busy_o <= 1'b0;
            mem_addr_o <= {AW{1'b0}};
            char_o <= 8'h00;
            valid_o <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_i && len_i != 8'h00) begin
                        mem_addr_o <= {AW{1'b0}};
                        left_q <= len_i;
                        busy_o <= 1'b1;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    // memory data for mem_addr_o is present now
                    byte_q <= mem_data_i;
                    char_o <= hex_char(mem_data_i[7:4]); // [RULE_05]
                    valid_o <= 1'b1;
                    state_q <= S_HI;
                end
                S_HI: begin
                    if (ready_i) begin
                        char_o <= hex_char(byte_q[3:0]); // [RULE_05]
                        state_q <= S_LO;
                    end
                end
                S_LO: begin
                    if (ready_i) begin
                        valid_o <= 1'b0;
                        left_q <= left_q - 8'h01;
                        if (left_q == 8'h01) begin
                            busy_o <= 1'b0;
                            state_q <= S_IDLE;
                        end else begin
                            mem_addr_o <= mem_addr_o + {{(AW-1){1'b0}}, 1'b1};
                            state_q <= S_WAIT;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// *** vhc_cmd_handler.v ***
// Operation
// [RULE_01] statistics start with signature, then sample counts
// [RULE_02] max and min take four bytes each
// [RULE_03] average and deviation: four bytes, 16.16
// [RULE_04] 18 bytes per tool, 54 for feature tools
// [RULE_05] each statistics byte sent as two hex characters
// [RULE_06] statistics block never exceeds 128 bytes
// [RULE_07] each read waits for a full sample set
// [RULE_08] code 09 triggers exactly one inspection
// [RULE_09] bad check character: answer NAK, no execution
// [RULE_10] good check: ACK, then validate, execute or drop
// [RULE_11] host should select host trigger source first
// [RULE_12] code 0A unlocks local monitor and keyboard
// [RULE_13] host sends 0B 07 then block mask
// [RULE_14] mask covers 213 blocks in bytes 3..29
// [RULE_15] byte 3 bit 0 is block 1, ascending
// [RULE_16] one packet per block, one write per command
// [RULE_17] no writes in setup; validate all after write
// [RULE_18] statistics restart from zero after sample count
// [RULE_19] unused top bits of byte 29 are ignored
// [RULE_20] trigger and unlock carry no operand bytes
`timescale 1ns/1ns
`include "vhc_map.vh"

module vhc_cmd_handler #(
    parameter CNT_W = 16,
    parameter AW = 7
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rstn_i,
    // received command bytes, already de-framed by the link layer
    input wire [7:0] rx_data_i,
    input wire rx_valid_i,
    input wire rx_last_i,
    input wire rx_bcc_ok_i,
    // link replies
    output reg reply_ack_o,
    output reg reply_nak_o,
    // device state and actions
    input wire setup_mode_i,
    output reg trig_o,
    output reg unlock_o,
    // configuration block write
    output reg [`VHC_NBLK-1:0] cfg_mask_o,
    output reg cfg_write_o,
    input wire cfg_done_i,
    output reg cfg_validate_o,
    // statistics accumulation
    input wire insp_done_i,
    input wire [CNT_W-1:0] sample_count_i,
    output reg [CNT_W-1:0] sample_idx_o,
    output reg stat_clear_o,
    input wire [3:0] stat_tools_i,
    input wire [1:0] stat_feat_tools_i,
    // statistics memory and character stream
    output wire [AW-1:0] stat_addr_o,
    input wire [7:0] stat_data_i,
    output wire [7:0] tx_char_o,
    output wire tx_valid_o,
    input wire tx_ready_i,
    output wire tx_busy_o
);
    reg [4:0] len_q;
    reg [7:0] code_q;
    reg [7:0] sub_q;
    reg [7:0] arg_q;
    reg [`VHC_MASK_W-1:0] shift_q;
    reg [7:0] pend_q;
    reg set_ready_q;
    reg tx_start_q;
    reg [7:0] blk_len_q;
    reg cfg_busy_q;

    wire [4:0] len_now;
    wire [7:0] code_now;
    wire [7:0] sub_now;
    wire [7:0] arg_now;
    wire end_ok;
    wire do_trig;
    wire do_unlock;
    wire do_wrcfg;
    wire do_rdstat;
    wire set_done;
    wire [7:0] blk_len;
    wire start_send;

    // statistics block length from the configured tool mix
    function [7:0] stat_len;
        input [3:0] tools;
        input [1:0] feats;
        reg [9:0] sum;
        begin
            sum = {2'h0, `VHC_SIG_BYTES}
                + ({6'h00, tools} * {2'h0, `VHC_TOOL_BYTES}) // [RULE_04]
                + ({8'h00, feats} * {2'h0, `VHC_FEAT_TOOL_BYTES});
            // the host keeps the selection within bounds; clamp anyway
            if (sum > {2'h0, `VHC_STAT_MAX}) // [RULE_06]
                stat_len = `VHC_STAT_MAX;
            else
                stat_len = sum[7:0];
        end
    endfunction

    // the final byte is judged together with the bytes already stored
    assign len_now = (len_q == `VHC_LEN_CAP) ? len_q : len_q + 5'h01;
    assign code_now = (len_now == `VHC_POS_CODE) ? rx_data_i : code_q;
    assign sub_now = (len_now == `VHC_POS_SUB) ? rx_data_i : sub_q;
    assign arg_now = (len_now == `VHC_POS_ARG) ? rx_data_i : arg_q;
    assign end_ok = rx_valid_i && rx_last_i && rx_bcc_ok_i; // [RULE_10]

    assign do_trig = end_ok && code_now == `VHC_OP_TRIG
        && len_now == `VHC_LEN_BARE; // [RULE_20]
    assign do_unlock = end_ok && code_now == `VHC_OP_UNLOCK
        && len_now == `VHC_LEN_BARE; // [RULE_20]
    assign do_wrcfg = end_ok && code_now == `VHC_OP_WRCFG
        && sub_now == `VHC_SUB_WRCFG && len_now == `VHC_LEN_WRCFG
        && !setup_mode_i && !cfg_busy_q; // [RULE_17]
    assign do_rdstat = end_ok && code_now == `VHC_OP_RDSTAT
        && sub_now == `VHC_SUB_ZERO && len_now == `VHC_LEN_RDSTAT;

    assign set_done = insp_done_i
        && (sample_idx_o + {{(CNT_W-1){1'b0}}, 1'b1} >= sample_count_i);
    assign blk_len = stat_len(stat_tools_i, stat_feat_tools_i);
    assign start_send = set_ready_q && pend_q != 8'h00 && !tx_busy_o
        && !tx_start_q;

    // command assembly and reply
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            len_q <= 5'h00;
            code_q <= 8'h00;
            sub_q <= 8'h00;
            arg_q <= 8'h00;
            shift_q <= {`VHC_MASK_W{1'b0}};
            reply_ack_o <= 1'b0;
            reply_nak_o <= 1'b0;
        end else begin
            reply_ack_o <= 1'b0;
            reply_nak_o <= 1'b0;
            if (rx_valid_i) begin
                if (rx_last_i) begin
                    len_q <= 5'h00;
                    reply_ack_o <= rx_bcc_ok_i; // [RULE_10]
                    reply_nak_o <= !rx_bcc_ok_i; // [RULE_09]
                end else begin
                    len_q <= len_now;
                end
                code_q <= code_now;
                sub_q <= sub_now;
                arg_q <= arg_now;
                // byte 3 ends lowest so block n sits at bit n-1
                if (len_now >= `VHC_MASK_FIRST)
                    shift_q <= {rx_data_i,
                        shift_q[`VHC_MASK_W-1:8]}; // [RULE_15]
            end
        end
    end

    // actions, each once per accepted command
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_o <= 1'b0;
            unlock_o <= 1'b0;
            cfg_write_o <= 1'b0;
            cfg_validate_o <= 1'b0;
            cfg_busy_q <= 1'b0;
            cfg_mask_o <= {`VHC_NBLK{1'b0}};
        end else begin
            trig_o <= do_trig; // [RULE_08]
            unlock_o <= do_unlock; // [RULE_12]
            cfg_write_o <= do_wrcfg; // [RULE_16]
            cfg_validate_o <= cfg_busy_q && cfg_done_i; // [RULE_17]
            if (do_wrcfg) begin
                cfg_busy_q <= 1'b1;
                // shift_q still lacks the last byte, take it directly
                cfg_mask_o <= {rx_data_i[4:0],
                    shift_q[`VHC_MASK_W-1:8]}; // [RULE_14] [RULE_19]
            end else if (cfg_done_i) begin
                cfg_busy_q <= 1'b0;
            end
        end
    end

    // sample accumulation and read scheduling
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_idx_o <= {CNT_W{1'b0}};
            stat_clear_o <= 1'b0;
            set_ready_q <= 1'b0;
            pend_q <= 8'h00;
            tx_start_q <= 1'b0;
            blk_len_q <= 8'h00;
        end else begin
            stat_clear_o <= set_done; // [RULE_18]
            if (set_done)
                sample_idx_o <= {CNT_W{1'b0}}; // [RULE_18]
            else if (insp_done_i)
                sample_idx_o <= sample_idx_o + {{(CNT_W-1){1'b0}}, 1'b1};
            // a set completing in the same cycle as a send still counts
            if (set_done)
                set_ready_q <= 1'b1; // [RULE_07]
            else if (start_send)
                set_ready_q <= 1'b0;
            // a new read adding to the queue and a send taking one in the same cycle both count
            if (do_rdstat)
                pend_q <= pend_q + arg_now - {7'h00, start_send};
            else if (start_send)
                pend_q <= pend_q - 8'h01; // [RULE_07]
            tx_start_q <= start_send;
            if (start_send)
                blk_len_q <= blk_len; // [RULE_01] [RULE_02] [RULE_03]
        end
    end

    vhc_stat_tx #(
        .AW(AW)
    ) u_stat_tx (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .start_i(tx_start_q),
        .len_i(blk_len_q),
        .busy_o(tx_busy_o),
        .mem_addr_o(stat_addr_o),
        .mem_data_i(stat_data_i),
        .char_o(tx_char_o),
        .valid_o(tx_valid_o),
        .ready_i(tx_ready_i)
    );
endmodule

// *** vhc_cmd_handler_chk_props.sv ***
`timescale 1ns/1ns
`include "vhc_map.vh"
module vhc_cmd_handler_chk #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // command side
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic rx_bcc_ok_i,
    input wire logic setup_mode_i,
    input wire logic cfg_done_i,
    // replies and actions
    input wire logic reply_ack_o,
    input wire logic reply_nak_o,
    input wire logic trig_o,
    input wire logic unlock_o,
    input wire logic cfg_write_o,
    input wire logic cfg_validate_o,
    // statistics
    input wire logic stat_clear_o,
    input wire logic [CNT_W-1:0] sample_idx_o,
    input wire logic [7:0] tx_char_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    a_ack_good: assert property (
        rx_valid_i && rx_last_i && rx_bcc_ok_i
        |=> reply_ack_o && !reply_nak_o)
        else $error("no ack");
    a_nak_bad: assert property (
        rx_valid_i && rx_last_i && !rx_bcc_ok_i
        |=> reply_nak_o && !reply_ack_o && !trig_o && !unlock_o
        && !cfg_write_o)
        else $error("bad nak");
    a_reply_cause: assert property (
        reply_ack_o || reply_nak_o
        |-> $past(rx_valid_i) && $past(rx_last_i))
        else $error("stray reply");
    // back to back commands may trigger on consecutive cycles
    a_trig_single: assert property (
        trig_o |-> reply_ack_o && $past(rx_valid_i) && $past(rx_last_i)
        && $past(rx_bcc_ok_i))
        else $error("trigger without command");
    a_unlock_acked: assert property (
        unlock_o |-> reply_ack_o && !trig_o)
        else $error("unlock");
    a_write_not_setup: assert property (
        cfg_write_o |-> reply_ack_o && !$past(setup_mode_i))
        else $error("write in setup");
    a_validate_cause: assert property (
        cfg_validate_o |-> $past(cfg_done_i))
        else $error("validate");
    a_char_hold: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_char_o))
        else $error("char dropped");
    a_char_hex: assert property (
        tx_valid_o |-> tx_char_o inside {[8'h30:8'h39], [8'h41:8'h46]})
        else $error("not hex");
    a_idx_restart: assert property (
        stat_clear_o |-> sample_idx_o == 0)
        else $error("idx");
    c_trig: cover property (trig_o);
    c_write: cover property (cfg_write_o);
    c_char: cover property (tx_valid_o && tx_ready_i);
endmodule
bind vhc_cmd_handler vhc_cmd_handler_chk #(.CNT_W(CNT_W)) chk_u (
    .ref_clk_i, .rstn_i, .rx_valid_i, .rx_last_i, .rx_bcc_ok_i,
    .setup_mode_i, .cfg_done_i, .reply_ack_o, .reply_nak_o, .trig_o,
    .unlock_o, .cfg_write_o, .cfg_validate_o, .stat_clear_o,
    .sample_idx_o, .tx_char_o, .tx_valid_o, .tx_ready_i
);

// *** vhc_host_mdl.sv ***
`timescale 1ns/1ns
module vhc_host_mdl (
    input wire logic ref_clk_i,
    input wire logic [6:0] stat_addr_o,
    output logic [7:0] stat_data_i,
    output logic tx_ready_i
);
    logic [1:0] cnt_q = 2'h0;
    // store read straight from the registered address: the handler
    // takes the byte in the cycle after it moves the address
    assign stat_data_i = {stat_addr_o[3:0], ~stat_addr_o[3:0]};
    // sink stalls one cycle in four so held characters get exercised
    always @(posedge ref_clk_i) begin
        cnt_q <= cnt_q + 2'h1;
        tx_ready_i <= #1 (cnt_q != 2'h0);
    end
endmodule

// *** vhc_cmd_handler_tb.sv ***
`timescale 1ns/1ns
`include "vhc_map.vh"
module vhc_cmd_handler_tb;
    logic ref_clk_i = 0, rstn_i = 0, rx_valid_i = 0, rx_last_i = 0;
    logic rx_bcc_ok_i = 0, setup_mode_i = 0, cfg_done_i = 0;
    logic insp_done_i = 0;
    logic [7:0] rx_data_i = 8'h00;
    logic [15:0] sample_count_i = 16'h0002;
    logic [3:0] stat_tools_i = 4'h1;
    logic [1:0] stat_feat_tools_i = 2'h0;
    wire reply_ack_o, reply_nak_o, trig_o, unlock_o, cfg_write_o;
    wire cfg_validate_o, stat_clear_o, tx_valid_o, tx_ready_i, tx_busy_o;
    wire [`VHC_NBLK-1:0] cfg_mask_o;
    wire [15:0] sample_idx_o;
    wire [6:0] stat_addr_o;
    wire [7:0] stat_data_i, tx_char_o;
    integer error_cnt = 0, comparisons = 0;
    logic [7:0] cb [0:30];
    logic [4:0] r;
    always #5 ref_clk_i = ~ref_clk_i;
    vhc_cmd_handler dut_u (
        .ref_clk_i, .rstn_i, .rx_data_i, .rx_valid_i, .rx_last_i,
        .rx_bcc_ok_i, .reply_ack_o, .reply_nak_o, .setup_mode_i, .trig_o,
        .unlock_o, .cfg_mask_o, .cfg_write_o, .cfg_done_i, .cfg_validate_o,
        .insp_done_i, .sample_count_i, .sample_idx_o, .stat_clear_o,
        .stat_tools_i, .stat_feat_tools_i, .stat_addr_o, .stat_data_i,
        .tx_char_o, .tx_valid_o, .tx_ready_i, .tx_busy_o
    );
    vhc_host_mdl host_u (.ref_clk_i, .stat_addr_o, .stat_data_i, .tx_ready_i);
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        end
    endtask
    function logic [7:0] hx(input logic [3:0] n);
        hx = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // r = {ack, nak, trig, unlock, write}, seen the cycle after the last byte
    task send(input integer n, input logic ok);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i) #1;
            rx_valid_i = 1;
            rx_data_i = cb[i];
            rx_last_i = (i == n - 1);
            rx_bcc_ok_i = ok;
        end
        @(posedge ref_clk_i) #1;
        rx_valid_i = 0;
        rx_last_i = 0;
        r = {reply_ack_o, reply_nak_o, trig_o, unlock_o, cfg_write_o};
    endtask
    task pulse(input integer which);
        @(posedge ref_clk_i) #1;
        if (which == 0) insp_done_i = 1; else cfg_done_i = 1;
        @(posedge ref_clk_i) #1;
        insp_done_i = 0;
        cfg_done_i = 0;
    endtask
    task t_bare;
        cb[0] = `VHC_OP_TRIG;
        // the bench stands in for the selected host trigger source
        send(1, 1'b1);
        chk("trig", 16'h0014, r);
        send(1, 1'b0);
        chk("nak", 16'h0008, r);
        cb[1] = 8'h00;
        send(2, 1'b1);
        chk("trig extra", 16'h0010, r);
        cb[0] = `VHC_OP_UNLOCK;
        send(1, 1'b1);
        chk("unlock", 16'h0012, r);
        send(2, 1'b1);
        chk("unlock extra", 16'h0010, r);
        $display("bare commands done");
    endtask
    task t_cfg;
        logic [2:0] sel;
        cb[0] = `VHC_OP_WRCFG;
        cb[1] = `VHC_SUB_WRCFG;
        for (int i = 2; i < 29; i++)
            cb[i] = 8'h00;
        cb[2] = 8'h01;
        cb[3] = 8'h80;
        cb[28] = 8'hF0;
        setup_mode_i = 1'b1;
        send(29, 1'b1);
        chk("setup write", 16'h0010, r);
        setup_mode_i = 1'b0;
        send(28, 1'b1);
        chk("short write", 16'h0010, r);
        send(29, 1'b1);
        chk("write", 16'h0011, r);
        sel = {cfg_mask_o[212], cfg_mask_o[15], cfg_mask_o[0]};
        chk("mask", 16'h0007, sel);
        chk("mask rest", 16'h0003, $countones(cfg_mask_o));
        send(29, 1'b1);
        chk("pending write", 16'h0010, r);
        pulse(1);
        chk("validate", 16'h0001, cfg_validate_o);
        $display("config write done");
    endtask
    // characters are taken at negedge, where valid and ready are settled
    task take_block(input integer n);
        logic [7:0] b, e;
        integer w;
        for (int k = 0; k < n; k++) begin
            w = 0;
            @(negedge ref_clk_i);
            while (!(tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
                && w < 50) begin
                w = w + 1;
                @(negedge ref_clk_i);
            end
            b = k / 2;
            e = k[0] ? hx(~b[3:0]) : hx(b[3:0]);
            chk("char", e, tx_char_o);
            @(posedge ref_clk_i);
        end
        repeat (6) @(negedge ref_clk_i);
        chk("block end", 16'h0000, {tx_busy_o, tx_valid_o});
    endtask
    task t_stat;
        cb[0] = `VHC_OP_RDSTAT;
        cb[1] = 8'h00;
        cb[2] = 8'h01;
        send(3, 1'b1);
        chk("read ack", 16'h0010, r);
        pulse(0);
        chk("idx", 16'h0001, sample_idx_o);
        repeat (5) @(negedge ref_clk_i);
        chk("early busy", 16'h0000, tx_busy_o);
        pulse(0);
        chk("clear", 16'h0001, stat_clear_o);
        chk("idx restart", 16'h0000, sample_idx_o);
        take_block(40);
        send(3, 1'b1);
        repeat (20) @(negedge ref_clk_i);
        chk("second read", 16'h0000, tx_busy_o);
        // one feature tool alone: signature plus three features
        stat_tools_i = 4'h0;
        stat_feat_tools_i = 2'h1;
        pulse(0);
        pulse(0);
        take_block(112);
        $display("statistics done");
    endtask
    task finish_test;
        $display("errors %0d compares %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        #1 rstn_i = 1;
        t_bare;
        t_cfg;
        t_stat;
        finish_test;
    end
endmodule
